/* File: design/psbi_bus_interface.sv */
`timescale 1ns/10ps
`include "psbi_regs.svh"
module psbi_bus_interface import psbi_pkg::*; #(
    parameter int ADDR_W = `PSBI_ADDR_W,
    parameter int DATA_W = `PSBI_DATA_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_clk,
    input wire psbi_core_s core_cyc,
    input wire logic [ADDR_W-1:0] core_address_bus,
    input wire logic [DATA_W-1:0] core_data_out,
    input wire logic [DATA_W-1:0] boot_rom_data,
    input wire logic boot_rom_select,
    input wire logic interrupt_cycle,
    input wire logic panel_op,
    input wire logic mirror_en,
    input wire logic [DATA_W-1:0] di_bus,
    input wire logic [DATA_W-1:0] panel_data_in,
    input wire logic prdy,
    input wire logic xrdy,
    input wire logic ssw_dsbl,
    input wire logic sta_dsbl_n,
    input wire logic cc_dsbl_n,
    input wire logic addr_dsbl_n,
    input wire logic do_dsbl_n,
    output logic core_wait_n,
    output logic [DATA_W-1:0] core_data_bus,
    output psbi_src_e core_data_src,
    output logic panel_to_core_gate,
    output logic input_bus_gate,
    output logic [DATA_W-1:0] panel_data_bus,
    output logic panel_data_oe,
    output logic [DATA_W-1:0] do_bus,
    output logic do_oe,
    output logic [ADDR_W-1:0] bp_address,
    output logic addr_oe,
    output psbi_stat_s stat,
    output logic stat_oe,
    output psbi_ctrl_s ctrl,
    output logic ctrl_oe,
    output logic sstack
);
    // =====================================
    // pin synchronisers (backplane domain)
    // =====================================
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic prdy_s;
    logic xrdy_s;
    logic ssw_s;
    logic sta_s;
    logic cc_s;
    logic addr_s;
    logic do_s;
    always_ff @(posedge bus_clk) begin
        if (reset) begin
            pin_s1_q <= 8'hFF;
            pin_s2_q <= 8'hFF;
        end else begin
            pin_s1_q <= {1'b1, prdy, xrdy, ~ssw_dsbl, sta_dsbl_n, cc_dsbl_n, addr_dsbl_n, do_dsbl_n};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign prdy_s = pin_s2_q[6];
    assign xrdy_s = pin_s2_q[5];
    assign ssw_s = ~pin_s2_q[4];
    assign sta_s = pin_s2_q[3];
    assign cc_s = pin_s2_q[2];
    assign addr_s = pin_s2_q[1];
    assign do_s = pin_s2_q[0];

    // =====================================
    // core cycle decode (core domain)
    // =====================================
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic inta;
    logic rom_rd;
    logic rd_cyc;
    logic io_cyc;
    logic wr_out;
    assign mem_rd = core_cyc.mreq & core_cyc.rd;
    assign mem_wr = core_cyc.mreq & core_cyc.wr;
    assign io_rd = core_cyc.iorq & core_cyc.rd;
    assign io_wr = core_cyc.iorq & core_cyc.wr;
    assign inta = core_cyc.iorq & core_cyc.m1;
    assign rom_rd = boot_rom_select & mem_rd;
    assign rd_cyc = mem_rd | io_rd;
    // port cycles only; an acknowledge keeps its plain address
    assign io_cyc = io_rd | io_wr;
    assign wr_out = mem_wr | io_wr;

    function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a, input logic io, input logic mir);
        logic [ADDR_W-1:0] r;
        r = a;
        if (io && mir) begin
            r = {a[`PSBI_HALF_W-1:0], a[`PSBI_HALF_W-1:0]};
        end
        return r;
    endfunction

    // =====================================
    // core-domain word register, crossed by toggle handshake
    // =====================================
    typedef struct packed {
        psbi_stat_s st;
        logic pdbin;
        logic pwr_n;
        logic pmreq_n;
        logic prfsh_n;
        logic psync;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic drive_do;
    } psbi_word_s;
    psbi_word_s word_d, word_q, word_bus_q;
    logic cyc_act;
    logic cyc_act_q;
    logic cyc_fall;
    logic sync_pend_q;
    logic tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_seen;
    assign cyc_act = core_cyc.mreq | core_cyc.iorq;
    assign cyc_fall = ~cyc_act & cyc_act_q;
    assign ack_seen = (ack_s2_q == tgl_q);

    always_comb begin
        word_d = '0;
        word_d.st.smemr = mem_rd;
        word_d.st.swo = wr_out;
        word_d.st.sinp = io_rd;
        word_d.st.shlta = core_cyc.halt;
        word_d.st.sm1 = core_cyc.m1 & ~core_cyc.iorq;
        word_d.st.sout = io_wr;
        word_d.st.sinta = inta;
        word_d.pdbin = rd_cyc | inta;
        word_d.pwr_n = ~wr_out;
        word_d.pmreq_n = ~core_cyc.mreq;
        word_d.prfsh_n = ~core_cyc.rfsh;
        word_d.psync = cyc_fall | sync_pend_q;
        word_d.addr = map_addr(core_address_bus, io_cyc, mirror_en);
        word_d.dout = core_data_out;
        word_d.drive_do = wr_out;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cyc_act_q <= 1'b0;
        end else begin
            cyc_act_q <= cyc_act;
        end
    end

    // the gap pulse is shorter than a handshake, so it waits for a word to carry it
    // a gap seen while a word launches rides in that word, so clearing then loses nothing
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_pend_q <= 1'b0;
        end else if (ack_seen) begin
            sync_pend_q <= 1'b0;
        end else if (cyc_fall) begin
            sync_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            word_q <= '0;
            tgl_q <= 1'b0;
        end else begin
            // new word is launched only after the previous one was taken
            if (ack_seen) begin
                word_q <= word_d;
                tgl_q <= ~tgl_q;
            end
        end
    end

    // wait request returns from the bus domain
    logic wait_s1_q;
    logic wait_s2_q;
    logic bus_tgl_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= bus_tgl_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wait_s1_q <= 1'b0;
            wait_s2_q <= 1'b0;
        end else begin
            wait_s1_q <= ~(prdy_s & xrdy_s);
            wait_s2_q <= wait_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            core_wait_n <= 1'b1;
        end else begin
            core_wait_n <= ~wait_s2_q;
        end
    end

    // =====================================
    // data bus steering (core domain)
    // =====================================
    logic ssw_c1_q;
    logic ssw_c2_q;
    logic [DATA_W-1:0] di_c1_q;
    logic [DATA_W-1:0] di_c2_q;
    logic [DATA_W-1:0] cp_c1_q;
    logic [DATA_W-1:0] cp_c2_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            ssw_c1_q <= 1'b0;
            ssw_c2_q <= 1'b0;
        end else begin
            ssw_c1_q <= ssw_dsbl;
            ssw_c2_q <= ssw_c1_q;
        end
    end

    // data pins are sampled as levels; a byte changing mid-sync may tear for one clock
    always_ff @(posedge clk) begin
        if (reset) begin
            di_c1_q <= '0;
            di_c2_q <= '0;
        end else begin
            di_c1_q <= di_bus;
            di_c2_q <= di_c1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cp_c1_q <= '0;
            cp_c2_q <= '0;
        end else begin
            cp_c1_q <= panel_data_in;
            cp_c2_q <= cp_c1_q;
        end
    end

    psbi_src_e src;
    logic pnl;
    assign pnl = panel_op | ssw_c2_q;
    always_comb begin
        // priority chain keeps the sources exclusive
        src = PSBI_SRC_NONE;
        if (pnl) begin
            src = PSBI_SRC_PANEL;
        end else if (rom_rd) begin
            src = PSBI_SRC_ROM;
        end else if (rd_cyc | inta | interrupt_cycle) begin
            src = PSBI_SRC_INPUT;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            core_data_src <= PSBI_SRC_NONE;
            panel_to_core_gate <= 1'b0;
            input_bus_gate <= 1'b0;
        end else begin
            core_data_src <= src;
            panel_to_core_gate <= (src == PSBI_SRC_PANEL);
            input_bus_gate <= (src == PSBI_SRC_INPUT);
        end
    end

    // idle cycles echo the core's own byte rather than leave a stale read standing
    always_ff @(posedge clk) begin
        if (reset) begin
            core_data_bus <= '0;
        end else begin
            unique case (src)
                PSBI_SRC_PANEL: core_data_bus <= cp_c2_q;
                PSBI_SRC_ROM: core_data_bus <= boot_rom_data;
                PSBI_SRC_INPUT: core_data_bus <= di_c2_q;
                PSBI_SRC_NONE: core_data_bus <= core_data_out;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            panel_data_bus <= '0;
            panel_data_oe <= 1'b0;
        end else begin
            panel_data_bus <= core_data_out;
            panel_data_oe <= ~pnl;
        end
    end

    // =====================================
    // backplane drivers (bus domain)
    // =====================================
    logic tgl_s1_q;
    logic tgl_s2_q;
    always_ff @(posedge bus_clk) begin
        if (reset) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
        end else begin
            tgl_s1_q <= tgl_q;
            tgl_s2_q <= tgl_s1_q;
        end
    end

    // word_q is stable while the toggle is outstanding
    always_ff @(posedge bus_clk) begin
        if (reset) begin
            bus_tgl_q <= 1'b0;
            word_bus_q <= '0;
        end else if (tgl_s2_q != bus_tgl_q) begin
            word_bus_q <= word_q;
            bus_tgl_q <= tgl_s2_q;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (reset) begin
            stat <= '0;
            stat_oe <= 1'b0;
        end else begin
            stat <= word_bus_q.st;
            stat_oe <= sta_s;
        end
    end

    // ready is taken from the synchronised pins, not the word, so the wait status does not lag the handshake
    always_ff @(posedge bus_clk) begin
        if (reset) begin
            ctrl <= '{psync: 1'b0, pdbin: 1'b0, pwait: 1'b0, pwr_n: 1'b1, pmreq_n: 1'b1, prfsh_n: 1'b1};
            ctrl_oe <= 1'b0;
        end else begin
            ctrl.psync <= word_bus_q.psync;
            ctrl.pdbin <= word_bus_q.pdbin;
            ctrl.pwait <= ~(prdy_s & xrdy_s);
            ctrl.pwr_n <= word_bus_q.pwr_n;
            ctrl.pmreq_n <= word_bus_q.pmreq_n;
            ctrl.prfsh_n <= word_bus_q.prfsh_n;
            ctrl_oe <= cc_s;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (reset) begin
            bp_address <= '0;
            addr_oe <= 1'b0;
        end else begin
            bp_address <= word_bus_q.addr;
            addr_oe <= addr_s;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (reset) begin
            do_bus <= '0;
            do_oe <= 1'b0;
        end else begin
            do_bus <= word_bus_q.dout;
            do_oe <= do_s & word_bus_q.drive_do;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (reset) begin
            sstack <= `PSBI_STACK_VAL;
        end else begin
            sstack <= `PSBI_STACK_VAL;
        end
    end

    logic unused_ok;
    assign unused_ok = ssw_s ^ pin_s2_q[7];
endmodule // psbi_bus_interface

/* File: inc/psbi_pkg.sv */
package psbi_pkg;
    // core-side cycle qualifiers, all active high
    typedef struct packed {
        logic mreq;
        logic iorq;
        logic rd;
        logic wr;
        logic m1;
        logic halt;
        logic rfsh;
    } psbi_core_s;
    // backplane status group
    typedef struct packed {
        logic smemr;
        logic swo;
        logic sinp;
        logic shlta;
        logic sm1;
        logic sout;
        logic sinta;
    } psbi_stat_s;
    // backplane control group; pwr and the two requests are active low
    typedef struct packed {
        logic psync;
        logic pdbin;
        logic pwait;
        logic pwr_n;
        logic pmreq_n;
        logic prfsh_n;
    } psbi_ctrl_s;
    typedef enum logic [1:0] {PSBI_SRC_NONE, PSBI_SRC_PANEL, PSBI_SRC_INPUT, PSBI_SRC_ROM} psbi_src_e;
endpackage

/* File: inc/psbi_regs.svh */
// Contract
// - Sync pulse between memory or I/O cycles, one or two clocks; here it lasts one handshake word, three or more clocks.
// - Wait status true while core is waiting on either ready line.
// - Active-low write strobe marks valid output data on writes and outputs.
// - Halt status true while core executes a halt.
// - Input status true for every port read.
// - Interrupt acknowledge status true through every acknowledge cycle.
// - Memory read status true through every memory read.
// - Fetch status on every opcode fetch; two-byte opcodes give two.
// - Output status true for every port write.
// - Stack status always false.
// - Sense switch disable swaps input receivers for panel receivers.
// - Status disable releases the seven status drivers.
// - Write-out status true while core sends data on output bus.
// - Low external ready puts the core into wait.
// - Panel bus gated onto core bus during panel operations.
// - Input bus gated on reads and interrupt cycles, not boot ROM reads.
// - Core bus drives panel bus when no panel operation runs.
// - Core bus gated onto output bus on memory writes and outputs.
// - Boot ROM select puts ROM data on core bus, input path off.
// - Address passes through except during I/O cycles.
// - With mirroring, I/O puts low address byte on both halves.
// - Low memory ready puts the core into wait.
// - Address disable releases the address drivers.
// - Output disable releases the output data drivers.
// - Control disable releases the six control drivers.
`ifndef PSBI_REGS_SVH
`define PSBI_REGS_SVH
`define PSBI_ADDR_W 16
`define PSBI_DATA_W 8
`define PSBI_HALF_W 8
`define PSBI_STACK_VAL 1'b0
`endif

/* File: verif/psbi_bus_interface_monitor.sv */
`timescale 1ns/10ps
module psbi_bus_monitor import psbi_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_clk,
    input wire logic xrdy,
    input wire logic sta_dsbl_n,
    input wire logic cc_dsbl_n,
    input wire logic addr_dsbl_n,
    input wire logic do_dsbl_n,
    input wire logic panel_to_core_gate,
    input wire logic input_bus_gate,
    input wire logic do_oe,
    input wire logic addr_oe,
    input wire psbi_stat_s stat,
    input wire logic stat_oe,
    input wire psbi_ctrl_s ctrl,
    input wire logic ctrl_oe,
    input wire logic sstack
);
    // ========================================
    // pins cross a sync chain; six samples low bounds its depth
    sequence s_low6(x);
        !x [*6];
    endsequence
    a_status_release: assert property (@(posedge bus_clk) disable iff (reset) s_low6(sta_dsbl_n) |-> !stat_oe)
        else $error("status drive while disabled");
    a_ctrl_release: assert property (@(posedge bus_clk) disable iff (reset) s_low6(cc_dsbl_n) |-> !ctrl_oe)
        else $error("control drive while disabled");
    a_addr_release: assert property (@(posedge bus_clk) disable iff (reset) s_low6(addr_dsbl_n) |-> !addr_oe)
        else $error("address drive while disabled");
    a_do_release: assert property (@(posedge bus_clk) disable iff (reset) s_low6(do_dsbl_n) |-> !do_oe)
        else $error("output data drive while disabled");
    a_xrdy_wait: assert property (@(posedge bus_clk) disable iff (reset) s_low6(xrdy) |-> ctrl.pwait)
        else $error("no wait status on low ready");
    a_write_strobe: assert property (@(posedge bus_clk) disable iff (reset) stat.swo |-> !ctrl.pwr_n)
        else $error("write status without strobe");
    a_stack_low: assert property (@(posedge bus_clk) disable iff (reset) !sstack)
        else $error("stack status raised");
    a_one_source: assert property (@(posedge clk) disable iff (reset) !(panel_to_core_gate && input_bus_gate))
        else $error("two sources on core bus");
endmodule // psbi_bus_monitor
bind psbi_bus_interface psbi_bus_monitor i_psbi_bus_monitor (.clk(clk), .reset(reset), .bus_clk(bus_clk),
    .xrdy(xrdy), .sta_dsbl_n(sta_dsbl_n), .cc_dsbl_n(cc_dsbl_n), .addr_dsbl_n(addr_dsbl_n),
    .do_dsbl_n(do_dsbl_n), .panel_to_core_gate(panel_to_core_gate), .input_bus_gate(input_bus_gate),
    .do_oe(do_oe), .addr_oe(addr_oe), .stat(stat), .stat_oe(stat_oe), .ctrl(ctrl), .ctrl_oe(ctrl_oe),
    .sstack(sstack));

/* File: verif/psbi_bus_interface_test.sv */
`timescale 1ns/10ps
module psbi_bus_interface_test import psbi_pkg::*;;
    // ========================================
    typedef struct packed {
        logic [15:0] a;
        psbi_stat_s s;
        logic [7:0] o;
        logic [7:0] c;
        logic [4:0] g;
        logic w;
        logic r;
    } psbi_exp_s;
    localparam psbi_core_s OPS [7] = '{7'h54, 7'h50, 7'h48, 7'h30, 7'h28, 7'h24, 7'h56};
    psbi_exp_s q[$];
    psbi_exp_s e, e2;
    psbi_core_s cyc = '0;
    logic clk = 0, bus_clk = 0, reset = 1, rsel = 0, icyc = 0, pop = 0, mir = 0, slow = 0, stop = 0, busy = 0;
    logic sta_n = 1, cc_n = 1, ad_n = 1, do_n = 1, prdy, xrdy, cwn, stat_oe, ctrl_oe, addr_oe, do_oe, sst;
    logic [15:0] addr = '0, bpa;
    logic [7:0] dout = '0, rom = '0, di = '0, sw = '0, rs = 8'h54, di_bus, pin, cdb, dob;
    psbi_stat_s stat;
    psbi_ctrl_s ctrl;
    psbi_src_e dsrc;
    logic pdoe, pgate, igate;
    logic [7:0] pdb;
    int m;
    int bad_count = 0, checked = 0, n;
    initial forever #10 clk = ~clk;
    initial begin
        #1.3;
        forever #3 bus_clk = ~bus_clk;
    end
    psbi_bus_interface i_psbi_bus_interface (.clk(clk), .reset(reset), .bus_clk(bus_clk), .core_cyc(cyc),
        .core_address_bus(addr), .core_data_out(dout), .boot_rom_data(rom), .boot_rom_select(rsel),
        .interrupt_cycle(icyc), .panel_op(pop), .mirror_en(mir), .di_bus(di_bus), .panel_data_in(pin),
        .prdy(prdy), .xrdy(xrdy), .ssw_dsbl(pop), .sta_dsbl_n(sta_n), .cc_dsbl_n(cc_n), .addr_dsbl_n(ad_n),
        .do_dsbl_n(do_n), .core_wait_n(cwn), .core_data_bus(cdb), .core_data_src(dsrc), .panel_to_core_gate(pgate),
        .input_bus_gate(igate), .panel_data_bus(pdb), .panel_data_oe(pdoe), .do_bus(dob), .do_oe(do_oe),
        .bp_address(bpa),
        .addr_oe(addr_oe), .stat(stat), .stat_oe(stat_oe), .ctrl(ctrl), .ctrl_oe(ctrl_oe), .sstack(sst));
    psbi_far_model i_psbi_far_model (.bus_clk(bus_clk), .reset(reset), .slow(slow), .stop(stop), .di_src(di),
        .sw_src(sw), .prdy(prdy), .xrdy(xrdy), .di_bus(di_bus), .panel_data_in(pin));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic hit(input psbi_exp_s x);
        return bpa === x.a && stat === x.s && (!x.w || dob === x.o) && (!x.r || cdb === x.c) &&
            {dsrc, pdoe, pgate, igate} === x.g && (!x.g[2] || pdb === x.o);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // second pass mirrors I/O; input 10 reads the panel, read 8 hits the boot ROM
    task automatic op(input int i);
        @(negedge clk);
        rs = lfsr(rs);
        addr = {lfsr(rs), rs};
        rs = lfsr(lfsr(rs));
        dout = rs;
        di = ~rs;
        sw = {rs[3:0], rs[7:4]};
        rom = rs ^ 8'h5A;
        cyc = OPS[i % 7];
        mir = i >= 7;
        pop = i == 10;
        rsel = i == 8;
        icyc = cyc.iorq & cyc.m1;
        e.a = (cyc.iorq & ~cyc.m1 & mir) ? {2{addr[7:0]}} : addr;
        e.s = {cyc.mreq & cyc.rd, cyc.wr, cyc.iorq & cyc.rd, cyc.halt, cyc.m1 & ~cyc.iorq, cyc.iorq & cyc.wr, icyc};
        e.o = dout;
        e.c = pop ? sw : rsel ? rom : di;
        e.w = cyc.wr;
        e.r = cyc.rd | icyc;
        e.g = {pop ? PSBI_SRC_PANEL : rsel ? PSBI_SRC_ROM : e.r ? PSBI_SRC_INPUT : PSBI_SRC_NONE, !pop, pop,
            !pop && !rsel && e.r};
        q.push_back(e);
        wait (q.size() == 0 && !busy);
        @(negedge clk);
        cyc = '0;
        for (m = 0; m < 12 && ctrl.psync !== 1'b1; m++) @(negedge clk);
        check(ctrl.psync, 1'b1);
        repeat (12) @(negedge clk);
        $display("test %0d done", i);
    endtask
    initial forever begin
        @(negedge clk);
        if (q.size() > 0) begin
            busy = 1;
            e2 = q.pop_front();
            for (n = 0; n < 100 && !hit(e2); n++) @(negedge clk);
            check(bpa, e2.a);
            check(stat, e2.s);
            if (e2.w) check({dob, ctrl.pwr_n}, {e2.o, 1'b0});
            if (e2.r) check(cdb, e2.c);
            check({dsrc, pdoe, pgate, igate}, e2.g);
            if (e2.g[2]) check(pdb, e2.o);
            busy = 0;
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        repeat (10) @(negedge clk);
        for (int i = 0; i < 14; i++) op(i);
        slow = 1;
        repeat (10) @(negedge clk);
        check({cwn, ctrl.pwait}, 2'h1);
        slow = 0;
        stop = 1;
        repeat (10) @(negedge clk);
        check({cwn, ctrl.pwait}, 2'h1);
        stop = 0;
        {sta_n, cc_n, ad_n, do_n} = 4'h0;
        repeat (10) @(negedge clk);
        check({stat_oe, ctrl_oe, addr_oe, do_oe, sst}, 5'h00);
        {sta_n, cc_n, ad_n, do_n} = 4'hF;
        repeat (10) @(negedge clk);
        check({stat_oe, ctrl_oe, addr_oe}, 3'h7);
        $display("test wait and release done");
        tally_and_finish;
    end
    initial begin
        #400000;
        bad_count++;
        tally_and_finish;
    end
endmodule // psbi_bus_interface_test

/* File: verif/psbi_far_model.sv */
`timescale 1ns/10ps
module psbi_far_model (
    input wire logic bus_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic stop,
    input wire logic [7:0] di_src,
    input wire logic [7:0] sw_src,
    output logic prdy,
    output logic xrdy,
    output logic [7:0] di_bus,
    output logic [7:0] panel_data_in
);
    // ========================================
    // each ready line has a single owner, so no contention
    always_ff @(posedge bus_clk) begin
        prdy <= reset | ~slow;
        xrdy <= reset | ~stop;
    end
    always_ff @(posedge bus_clk) begin
        di_bus <= di_src;
        panel_data_in <= sw_src;
    end
endmodule // psbi_far_model
